// [hdl/pwmu_params.svh]
// Constants of the PWM unit: register addresses, field positions, reset values.
// Assumes an 8-bit special function register port with 8-bit addresses.
// How it works
// - The quad generator has four channels, each enabled on its own.
// - All four channels share one 16-bit counter on the count clock.
// - Counter counts up from zero; output toggles at the channel compare match.
// - Counter wraps after the period value; one period is period plus one clocks.
// - With polarity 1, pulse width in clocks equals the compare value; with polarity 0 it is period plus one minus compare.
// - Compare value zero gives zero duty; output never goes active.
// - Compare above period gives full duty; output never toggles.
// - New period and compare values take effect only at the wrap or when the quad generator starts.
// - Polarity 0: high after compare match; polarity 1: high from overflow.
// - Counter reloads at each wrap; stops and clears only when disabled.
// - Channels one to three may use channel zero's compare value.
// - The two single-channel generators count independently on the count clock.
// - Single generator drives high for high count, low for low count, repeating.
// - Enable register bits 0..2 enable quad, first and second single generators.
// - Enable register bits 3..5 pick channel zero's duty for channels one to three.
// - Channel control bits 0..3 are enables, bits 4..7 polarity selects.
`ifndef PWMU_PARAMS_SVH
`define PWMU_PARAMS_SVH
`define PWMU_A_G1_LT_LO 8'h99
`define PWMU_A_G1_LT_HI 8'h9a
`define PWMU_A_G1_HT_LO 8'h9b
`define PWMU_A_G1_HT_HI 8'h9c
`define PWMU_A_G2_LT_LO 8'h9d
`define PWMU_A_G2_LT_HI 8'h9e
`define PWMU_A_G2_HT_LO 8'h9f
`define PWMU_A_G2_HT_HI 8'ha1
`define PWMU_A_GEN_EN 8'ha2
`define PWMU_A_QUAD_CTRL 8'ha3
`define PWMU_A_CMP0_LO 8'ha4
`define PWMU_A_CMP0_HI 8'ha5
`define PWMU_A_CMP1_LO 8'ha6
`define PWMU_A_CMP1_HI 8'ha7
`define PWMU_A_CMP2_LO 8'ha9
`define PWMU_A_CMP2_HI 8'haa
`define PWMU_A_CMP3_LO 8'hab
`define PWMU_A_CMP3_HI 8'hac
`define PWMU_A_PER_LO 8'had
`define PWMU_A_PER_HI 8'hae
`define PWMU_RST_BYTE 8'h00
`define PWMU_RST_WORD 16'h0000
`define PWMU_EN_QUAD 0
`define PWMU_EN_G1 1
`define PWMU_EN_G2 2
`define PWMU_EN_SRC_LSB 3
`define PWMU_EN_MASK 8'h3f
`define PWMU_CTRL_POL_LSB 4
`define PWMU_COUNT_MHZ 24
`endif

// [hdl/pwmu_pkg.sv]
// Types shared by the PWM unit files.
// Assumes pwmu_params.svh sits beside it on the include path.
`default_nettype none
package pwmu_pkg;
    typedef logic [7:0] pwmu_byte_t;
    typedef logic [15:0] pwmu_word_t;
    typedef enum logic {PWMU_PH_HIGH, PWMU_PH_LOW} pwmu_phase_t;
endpackage : pwmu_pkg
`default_nettype wire

// [hdl/pwmu_single.sv]
// One single-channel generator: high for a high count, low for a low count.
// Assumes settings arrive already assembled and enable comes from a register.
`default_nettype none
module pwmu_single
    import pwmu_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk, // System clock, also the count clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic enable, // Generator enable.
    input wire logic [WIDTH-1:0] highTime, // High time count.
    input wire logic [WIDTH-1:0] lowTime, // Low time count.
    output logic pwmOut // Waveform, registered.
);
    pwmu_phase_t phase_r;
    logic [WIDTH-1:0] count_r;

    // Phase sequencing; a zero-length phase is skipped so a zero high time gives a flat low.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_r <= PWMU_PH_HIGH;
            count_r <= '0;
        end else if (!enable) begin
            phase_r <= PWMU_PH_HIGH;
            count_r <= '0;
        end else begin
            unique case (phase_r)
                PWMU_PH_HIGH: begin
                    if (count_r + 1'b1 >= highTime) begin
                        phase_r <= (lowTime != '0) ? PWMU_PH_LOW : PWMU_PH_HIGH;
                        count_r <= '0;
                    end else begin
                        count_r <= count_r + 1'b1;
                    end
                end
                PWMU_PH_LOW: begin
                    if (count_r + 1'b1 >= lowTime) begin
                        phase_r <= (highTime != '0) ? PWMU_PH_HIGH : PWMU_PH_LOW;
                        count_r <= '0;
                    end else begin
                        count_r <= count_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Output follows the phase one cycle later, straight from a flip-flop.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwmOut <= 1'b0;
        end else begin
            pwmOut <= enable && phase_r == PWMU_PH_HIGH && highTime != '0;
        end
    end
endmodule : pwmu_single
`default_nettype wire

// [hdl/pwmu_top.sv]
// PWM unit: a four-channel generator on one shared counter plus two single-channel generators.
// Assumes the special function register port is synchronous and the count clock equals sys_clk.
`include "pwmu_params.svh"
`default_nettype none
module pwmu_top #(
    parameter int CHANNELS = 4,
    parameter int WIDTH = 16
) (
    input wire logic sys_clk, // System clock, 24 MHz count clock in the device.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire pwmu_pkg::pwmu_byte_t sfrAddr, // Register address.
    input wire pwmu_pkg::pwmu_byte_t sfrWdata, // Write data.
    input wire logic sfrWe, // Write strobe, one cycle.
    input wire logic sfrRe, // Read strobe, one cycle.
    output pwmu_pkg::pwmu_byte_t sfrRdata, // Read data, registered.
    output logic [CHANNELS-1:0] quadOut, // Quad generator channel outputs.
    output logic gen1Out, // First single generator output.
    output logic gen2Out // Second single generator output.
);
    import pwmu_pkg::*;

    // Software-visible bytes.
    pwmu_byte_t genEnable_r, quadCtrl_r;
    pwmu_byte_t g1LtLo_r, g1LtHi_r, g1HtLo_r, g1HtHi_r;
    pwmu_byte_t g2LtLo_r, g2LtHi_r, g2HtLo_r, g2HtHi_r;
    pwmu_byte_t perLo_r, perHi_r;
    pwmu_byte_t cmpLo_r [CHANNELS];
    pwmu_byte_t cmpHi_r [CHANNELS];

    // Assembled words, updated only on the completing byte.
    pwmu_word_t g1Low_r, g1High_r, g2Low_r, g2High_r;
    pwmu_word_t perStage_r;
    pwmu_word_t cmpStage_r [CHANNELS];

    // Words the counter really uses, loaded at the wrap.
    pwmu_word_t perActive_r;
    pwmu_word_t cmpActive_r [CHANNELS];
    pwmu_word_t count_r;
    logic running_r;

    logic quadEn;
    logic [CHANNELS-1:0] chanEn, chanPol;
    logic [CHANNELS-1:0] useCh0;
    logic wrapNow;
    logic [CHANNELS-1:0] cmpAddrLo, cmpAddrHi;

    assign quadEn = genEnable_r[`PWMU_EN_QUAD];
    assign chanEn = quadCtrl_r[CHANNELS-1:0];
    assign chanPol = quadCtrl_r[`PWMU_CTRL_POL_LSB +: CHANNELS];
    // Channel zero always uses its own value; the others follow their select bit.
    assign useCh0 = {genEnable_r[`PWMU_EN_SRC_LSB +: CHANNELS-1], 1'b0};
    assign wrapNow = running_r && (count_r >= perActive_r);

    // Compare address map is not contiguous, so it is spelled out per channel.
    always_comb begin
        cmpAddrLo = '0;
        cmpAddrHi = '0;
        cmpAddrLo[0] = sfrAddr == `PWMU_A_CMP0_LO;
        cmpAddrHi[0] = sfrAddr == `PWMU_A_CMP0_HI;
        cmpAddrLo[1] = sfrAddr == `PWMU_A_CMP1_LO;
        cmpAddrHi[1] = sfrAddr == `PWMU_A_CMP1_HI;
        cmpAddrLo[2] = sfrAddr == `PWMU_A_CMP2_LO;
        cmpAddrHi[2] = sfrAddr == `PWMU_A_CMP2_HI;
        cmpAddrLo[3] = sfrAddr == `PWMU_A_CMP3_LO;
        cmpAddrHi[3] = sfrAddr == `PWMU_A_CMP3_HI;
    end

    // Control and single-generator bytes; single-generator words assemble on the high byte.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            genEnable_r <= `PWMU_RST_BYTE;
            quadCtrl_r <= `PWMU_RST_BYTE;
            g1LtLo_r <= `PWMU_RST_BYTE;
            g1LtHi_r <= `PWMU_RST_BYTE;
            g1HtLo_r <= `PWMU_RST_BYTE;
            g1HtHi_r <= `PWMU_RST_BYTE;
            g2LtLo_r <= `PWMU_RST_BYTE;
            g2LtHi_r <= `PWMU_RST_BYTE;
            g2HtLo_r <= `PWMU_RST_BYTE;
            g2HtHi_r <= `PWMU_RST_BYTE;
            g1Low_r <= `PWMU_RST_WORD;
            g1High_r <= `PWMU_RST_WORD;
            g2Low_r <= `PWMU_RST_WORD;
            g2High_r <= `PWMU_RST_WORD;
        end else if (sfrWe) begin
            unique case (sfrAddr)
                `PWMU_A_GEN_EN: genEnable_r <= sfrWdata & `PWMU_EN_MASK;
                `PWMU_A_QUAD_CTRL: quadCtrl_r <= sfrWdata;
                `PWMU_A_G1_LT_LO: g1LtLo_r <= sfrWdata;
                `PWMU_A_G1_LT_HI: begin
                    g1LtHi_r <= sfrWdata;
                    g1Low_r <= {sfrWdata, g1LtLo_r};
                end
                `PWMU_A_G1_HT_LO: g1HtLo_r <= sfrWdata;
                `PWMU_A_G1_HT_HI: begin
                    g1HtHi_r <= sfrWdata;
                    g1High_r <= {sfrWdata, g1HtLo_r};
                end
                `PWMU_A_G2_LT_LO: g2LtLo_r <= sfrWdata;
                `PWMU_A_G2_LT_HI: begin
                    g2LtHi_r <= sfrWdata;
                    g2Low_r <= {sfrWdata, g2LtLo_r};
                end
                `PWMU_A_G2_HT_LO: g2HtLo_r <= sfrWdata;
                `PWMU_A_G2_HT_HI: begin
                    g2HtHi_r <= sfrWdata;
                    g2High_r <= {sfrWdata, g2HtLo_r};
                end
                default: begin
                end
            endcase
        end
    end

    // Period staging: the low byte waits until the high byte completes the word.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            perLo_r <= `PWMU_RST_BYTE;
            perHi_r <= `PWMU_RST_BYTE;
            perStage_r <= `PWMU_RST_WORD;
        end else if (sfrWe && sfrAddr == `PWMU_A_PER_LO) begin
            perLo_r <= sfrWdata;
        end else if (sfrWe && sfrAddr == `PWMU_A_PER_HI) begin
            perHi_r <= sfrWdata;
            perStage_r <= {sfrWdata, perLo_r};
        end
    end

    // Per-channel compare bytes, staged words and active copies.
    for (genvar c = 0; c < CHANNELS; c++) begin : gChan
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                cmpLo_r[c] <= `PWMU_RST_BYTE;
                cmpHi_r[c] <= `PWMU_RST_BYTE;
                cmpStage_r[c] <= `PWMU_RST_WORD;
            end else if (sfrWe && cmpAddrLo[c]) begin
                cmpLo_r[c] <= sfrWdata;
            end else if (sfrWe && cmpAddrHi[c]) begin
                cmpHi_r[c] <= sfrWdata;
                cmpStage_r[c] <= {sfrWdata, cmpLo_r[c]};
            end
        end

        // Active compare follows the staged word while stopped and otherwise changes only at the wrap.
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                cmpActive_r[c] <= `PWMU_RST_WORD;
            end else if (!running_r || wrapNow) begin
                cmpActive_r[c] <= useCh0[c] ? cmpStage_r[0] : cmpStage_r[c];
            end
        end

        // Output level: before the match the channel is in its overflow half.
        // Compare zero never matches low half, compare above period never leaves it.
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                quadOut[c] <= 1'b0;
            end else if (!running_r || !chanEn[c]) begin
                quadOut[c] <= 1'b0;
            end else if (cmpActive_r[c] == `PWMU_RST_WORD) begin
                quadOut[c] <= 1'b0;
            end else if (cmpActive_r[c] > perActive_r) begin
                quadOut[c] <= 1'b1;
            end else begin
                // With polarity 1 the pulse spans counts 0..cmp-1, so its width is cmp clocks; polarity 0 spans cmp..period.
                quadOut[c] <= (count_r < cmpActive_r[c]) ^ ~chanPol[c];
            end
        end
    end

    // Shared counter: runs from zero while enabled, wraps past the period, clears when disabled.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_r <= `PWMU_RST_WORD;
            running_r <= 1'b0;
            perActive_r <= `PWMU_RST_WORD;
        end else if (!quadEn) begin
            count_r <= `PWMU_RST_WORD;
            running_r <= 1'b0;
            perActive_r <= perStage_r;
        end else if (!running_r) begin
            running_r <= 1'b1;
            count_r <= `PWMU_RST_WORD;
            perActive_r <= perStage_r;
        end else if (wrapNow) begin
            count_r <= `PWMU_RST_WORD;
            perActive_r <= perStage_r;
        end else begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Two independent single-channel generators.
    pwmu_single #(.WIDTH(WIDTH)) uGen1 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(genEnable_r[`PWMU_EN_G1]),
        .highTime(g1High_r),
        .lowTime(g1Low_r),
        .pwmOut(gen1Out)
    );

    pwmu_single #(.WIDTH(WIDTH)) uGen2 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable(genEnable_r[`PWMU_EN_G2]),
        .highTime(g2High_r),
        .lowTime(g2Low_r),
        .pwmOut(gen2Out)
    );

    // Read port: registered, unmapped addresses read zero.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfrRdata <= `PWMU_RST_BYTE;
        end else if (sfrRe) begin
            unique case (sfrAddr)
                `PWMU_A_G1_LT_LO: sfrRdata <= g1LtLo_r;
                `PWMU_A_G1_LT_HI: sfrRdata <= g1LtHi_r;
                `PWMU_A_G1_HT_LO: sfrRdata <= g1HtLo_r;
                `PWMU_A_G1_HT_HI: sfrRdata <= g1HtHi_r;
                `PWMU_A_G2_LT_LO: sfrRdata <= g2LtLo_r;
                `PWMU_A_G2_LT_HI: sfrRdata <= g2LtHi_r;
                `PWMU_A_G2_HT_LO: sfrRdata <= g2HtLo_r;
                `PWMU_A_G2_HT_HI: sfrRdata <= g2HtHi_r;
                `PWMU_A_GEN_EN: sfrRdata <= genEnable_r;
                `PWMU_A_QUAD_CTRL: sfrRdata <= quadCtrl_r;
                `PWMU_A_CMP0_LO: sfrRdata <= cmpLo_r[0];
                `PWMU_A_CMP0_HI: sfrRdata <= cmpHi_r[0];
                `PWMU_A_CMP1_LO: sfrRdata <= cmpLo_r[1];
                `PWMU_A_CMP1_HI: sfrRdata <= cmpHi_r[1];
                `PWMU_A_CMP2_LO: sfrRdata <= cmpLo_r[2];
                `PWMU_A_CMP2_HI: sfrRdata <= cmpHi_r[2];
                `PWMU_A_CMP3_LO: sfrRdata <= cmpLo_r[3];
                `PWMU_A_CMP3_HI: sfrRdata <= cmpHi_r[3];
                `PWMU_A_PER_LO: sfrRdata <= perLo_r;
                `PWMU_A_PER_HI: sfrRdata <= perHi_r;
                default: sfrRdata <= `PWMU_RST_BYTE;
            endcase
        end
    end
endmodule : pwmu_top
`default_nettype wire

// [dv/pwmu_top_assertions.sv]
// Port-level checks of the PWM unit: register read-back and output quieting.
// Assumes it is bound into pwmu_top and shares its clock and reset.
`default_nettype none
module pwmu_top_assertions
    import pwmu_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int WIDTH = 16
) (
    input wire logic sys_clk, // Clock.
    input wire logic sys_rst, // Reset, active high.
    input wire pwmu_pkg::pwmu_byte_t sfrAddr, // Address.
    input wire pwmu_pkg::pwmu_byte_t sfrWdata, // Write data.
    input wire logic sfrWe, // Write strobe.
    input wire logic sfrRe, // Read strobe.
    input wire pwmu_pkg::pwmu_byte_t sfrRdata, // Read data.
    input wire logic [CHANNELS-1:0] quadOut, // Quad outputs.
    input wire logic gen1Out, // First single output.
    input wire logic gen2Out // Second single output.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Holes and unused bits read as zero; read data only moves after a read.
    rd_hole_zero_a: assert property (sfrRe && (sfrAddr == 8'ha0 || sfrAddr == 8'ha8) |=> sfrRdata == 8'h00)
        else $error("unmapped read not zero");
    en_top_zero_a: assert property (sfrRe && sfrAddr == 8'ha2 |=> sfrRdata[7:6] == 2'b00)
        else $error("enable spare bits not zero");
    rd_data_hold_a: assert property (!sfrRe |=> $stable(sfrRdata))
        else $error("read data moved without a read");
    // Outputs come out of reset low, and a cleared enable silences its output.
    rst_out_low_a: assert property ($fell(sys_rst) |-> quadOut == '0 && !gen1Out && !gen2Out)
        else $error("outputs not low after reset");
    quad_off_low_a: assert property (sfrWe && sfrAddr == 8'ha2 && !sfrWdata[0] |-> ##[1:3] quadOut == '0)
        else $error("quad outputs live after disable");
    gen1_off_low_a: assert property (sfrWe && sfrAddr == 8'ha2 && !sfrWdata[1] |-> ##[1:3] !gen1Out)
        else $error("first single output live after disable");
    gen2_off_low_a: assert property (sfrWe && sfrAddr == 8'ha2 && !sfrWdata[2] |-> ##[1:3] !gen2Out)
        else $error("second single output live after disable");
    chan_off_low_a: assert property (sfrWe && sfrAddr == 8'ha3 && !sfrWdata[0] |-> ##[1:3] !quadOut[0])
        else $error("channel zero live after disable");
endmodule : pwmu_top_assertions
bind pwmu_top pwmu_top_assertions #(.CHANNELS(CHANNELS), .WIDTH(WIDTH)) chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrRdata(sfrRdata), .quadOut(quadOut),
    .gen1Out(gen1Out), .gen2Out(gen2Out));
`default_nettype wire

// [dv/pwmu_load.sv]
// Pin load model: measures each completed high pulse on a PWM pin.
// Assumes the pin is sampled on the clock the generator counts on.
`default_nettype none
module pwmu_load (
    input wire logic sys_clk, // Sampling clock.
    input wire logic pin, // Driven PWM pin.
    output int highRun // Length of the last completed high pulse.
);
    timeunit 1ns;
    timeprecision 1ns;
    int run = 0;
    // A load only sees whole pulses, so a run counts once the pin falls.
    always @(posedge sys_clk) begin
        if (pin === 1'b1) run <= run + 1;
        else begin
            if (run != 0) highRun <= run;
            run <= 0;
        end
    end
endmodule : pwmu_load
`default_nettype wire

// [dv/pwmu_top_test.sv]
// Self-checking bench of the PWM unit: register map, quad duty cycles, single generators.
// Assumes pwmu_top, its checker and the pwmu_load model are compiled before it.
`include "pwmu_params.svh"
`default_nettype none
module pwmu_top_test import pwmu_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    pwmu_byte_t sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
    logic sfrWe = 1'b0, sfrRe = 1'b0, gen1Out, gen2Out;
    logic [3:0] quadOut;
    int errors = 0, totalChecks = 0, seed = 32'hc08f, run1, run2;
    int hiCnt[6];
    pwmu_byte_t regModel[256] = '{default: 8'h00};
    pwmu_byte_t addrList[$] = '{8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha1, 8'ha2, 8'ha3,
        8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae};
    pwmu_byte_t cmpA[4] = '{8'ha4, 8'ha6, 8'ha9, 8'hab};
    pwmu_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWe(sfrWe),
        .sfrRe(sfrRe), .sfrRdata(sfrRdata), .quadOut(quadOut), .gen1Out(gen1Out), .gen2Out(gen2Out));
    pwmu_load load1 (.sys_clk(sys_clk), .pin(gen1Out), .highRun(run1));
    pwmu_load load2 (.sys_clk(sys_clk), .pin(gen2Out), .highRun(run2));
    // Free-running 100 MHz clock.
    initial forever #5 sys_clk = ~sys_clk;
    task automatic chkByte(input string what, input pwmu_byte_t exp, input pwmu_byte_t got);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chkByte
    task automatic chkCount(input string what, input int exp, input int got);
        totalChecks++;
        if (got != exp) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chkCount
    // One write; the model keeps mapped bytes only, the enable byte masked.
    task automatic wr(input pwmu_byte_t a, input pwmu_byte_t d);
        @(posedge sys_clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWe <= 1'b1;
        @(posedge sys_clk);
        sfrWe <= 1'b0;
        if (a inside {addrList}) regModel[a] = (a == `PWMU_A_GEN_EN) ? d & `PWMU_EN_MASK : d;
    endtask : wr
    // Low byte first, so the word is only assembled by the high byte.
    task automatic wr16(input pwmu_byte_t lo, input pwmu_byte_t hi, input pwmu_word_t v);
        wr(lo, v[7:0]);
        wr(hi, v[15:8]);
    endtask : wr16
    task automatic rdChk(input pwmu_byte_t a);
        @(posedge sys_clk);
        sfrAddr <= a;
        sfrRe <= 1'b1;
        @(posedge sys_clk);
        sfrRe <= 1'b0;
        @(negedge sys_clk);
        chkByte($sformatf("reg %h", a), regModel[a], sfrRdata);
    endtask : rdChk
    // Counting high cycles over whole periods makes the result phase-free.
    task automatic measure(input int n);
        hiCnt = '{default: 0};
        repeat (n) begin
            @(negedge sys_clk);
            for (int i = 0; i < 4; i++) hiCnt[i] += int'(quadOut[i] === 1'b1);
            hiCnt[4] += int'(gen1Out === 1'b1);
            hiCnt[5] += int'(gen2Out === 1'b1);
        end
    endtask : measure
    function automatic int qHigh(input int c, input int p, input bit pol);
        if (c == 0) return 0;
        if (c > p) return p + 1;
        return pol ? c : p + 1 - c;
    endfunction : qHigh
    task automatic testDone();
        $display("Checks %0d mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : testDone
    // Watchdog: the whole sequence needs well under ten thousand cycles.
    initial begin
        #100us;
        errors++;
        testDone();
    end
    // Main sequence: register map, then four quad and single-generator setups, then shutdown.
    initial begin
        pwmu_word_t cmp[4];
        pwmu_byte_t ctrl[2];
        int sel, h2, c;
        ctrl = '{8'h0f, 8'hf5};
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (addrList[i]) rdChk(addrList[i]);
        foreach (addrList[i]) begin
            // The quad enable is forced on so that later quad settings are written while it runs.
            wr(addrList[i], 8'($random(seed)) | 8'(addrList[i] == `PWMU_A_GEN_EN));
            rdChk(addrList[i]);
        end
        wr(8'ha8, 8'h5a);
        rdChk(8'ha8);
        rdChk(8'ha0);
        wr(`PWMU_A_GEN_EN, 8'h00);
        for (int k = 0; k < 4; k++) begin
            sel = k[1] ? 8'h38 : 8'h00;
            cmp = '{16'd3, 16'({$random(seed)} % 10), 16'd8, 16'd7};
            h2 = 1 + {$random(seed)} % 7;
            wr(`PWMU_A_GEN_EN, 8'(1 | sel));
            wr16(`PWMU_A_PER_LO, `PWMU_A_PER_HI, 16'd7);
            for (int i = 0; i < 4; i++) wr16(cmpA[i], cmpA[i] + 8'h01, cmp[i]);
            wr16(`PWMU_A_G1_HT_LO, `PWMU_A_G1_HT_HI, 16'd3);
            wr16(`PWMU_A_G1_LT_LO, `PWMU_A_G1_LT_HI, 16'd5);
            wr16(`PWMU_A_G2_HT_LO, `PWMU_A_G2_HT_HI, 16'(h2));
            wr16(`PWMU_A_G2_LT_LO, `PWMU_A_G2_LT_HI, 16'(8 - h2));
            wr(`PWMU_A_QUAD_CTRL, ctrl[k[0]]);
            // First pass: a restart loads the staged period, else the random one would have to wrap first.
            if (k == 0) wr(`PWMU_A_GEN_EN, 8'(sel));
            wr(`PWMU_A_GEN_EN, 8'(7 | sel));
            repeat (24) @(posedge sys_clk);
            measure(32);
            for (int i = 0; i < 4; i++) begin
                c = (i > 0 && sel[2 + i]) ? cmp[0] : cmp[i];
                chkCount($sformatf("chan %0d", i), ctrl[k[0]][i] ? 4 * qHigh(c, 7, ctrl[k[0]][4 + i]) : 0,
                    hiCnt[i]);
            end
            chkCount("gen1 high", 12, hiCnt[4]);
            chkCount("gen2 high", 4 * h2, hiCnt[5]);
            chkCount("gen1 pulse", 3, run1);
            chkCount("gen2 pulse", h2, run2);
        end
        wr(`PWMU_A_QUAD_CTRL, 8'h00);
        wr(`PWMU_A_GEN_EN, 8'h00);
        repeat (4) @(posedge sys_clk);
        measure(16);
        chkCount("quiet", 0, hiCnt.sum());
        testDone();
    end
endmodule : pwmu_top_test
`default_nettype wire
